// >>> pewc_defines.svh
// constants of the parallel EEPROM write controller: offsets, fields, timing
// assumes a 100 MHz system clock and a byte-wide EEPROM with async strobes
`ifndef PEWC_DEFINES_SVH
`define PEWC_DEFINES_SVH
// register byte offsets
`define PEWC_REG_CMD 5'h00
`define PEWC_REG_ADDR 5'h04
`define PEWC_REG_WDATA 5'h08
`define PEWC_REG_STATUS 5'h0C
`define PEWC_REG_RDATA 5'h10
// status bit positions
`define PEWC_ST_BUSY 0
`define PEWC_ST_PAGE_OPEN 1
`define PEWC_ST_REFUSED 2
`define PEWC_ST_PROG_DONE 3
`define PEWC_ST_TOGGLE 4
// timing, in ns / us, and derived cycle counts
`define PEWC_CLK_NS 10
`define PEWC_ACCESS_NS 70
`define PEWC_STROBE_NS 100
`define PEWC_BLW_US 100
`define PEWC_ACCESS_CYC ((`PEWC_ACCESS_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS)
`define PEWC_STROBE_CYC ((`PEWC_STROBE_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS)
`define PEWC_BLW_CYC ((`PEWC_BLW_US * 1000) / `PEWC_CLK_NS)
`define PEWC_SYNC_CYC 2
`define PEWC_PAGE_BYTES 64
// command sequence addresses and data
`define PEWC_SEQ_A1 13'h1555
`define PEWC_SEQ_A2 13'h0AAA
`define PEWC_SEQ_D1 8'hAA
`define PEWC_SEQ_D2 8'h55
`define PEWC_SEQ_D3_UNLOCK 8'hA0
`define PEWC_SEQ_D3_UNPROT 8'h80
`define PEWC_SEQ_D6_UNPROT 8'h20
`endif

// >>> pewc_pkg.sv
// types of the parallel EEPROM write controller
// assumes pewc_defines.svh for numeric constants
package pewc_pkg;
   typedef enum logic [2:0]
   {
      PEWC_CMD_NONE = 3'h0,
      PEWC_CMD_READ = 3'h1,
      PEWC_CMD_LOAD = 3'h2,
      PEWC_CMD_UNLOCK = 3'h3,
      PEWC_CMD_UNPROT = 3'h4,
      PEWC_CMD_POLL = 3'h5
   } pewc_cmd_t;

   typedef enum logic [2:0]
   {
      PEWC_IDLE = 3'h0,
      PEWC_W_SEL = 3'h1,
      PEWC_W_LOW = 3'h2,
      PEWC_W_REL = 3'h3,
      PEWC_R_ACC = 3'h4,
      PEWC_R_END = 3'h5
   } pewc_state_t;

   typedef struct packed
   {
      pewc_state_t st;
      pewc_cmd_t kind;
      logic [2:0] idx;
      logic [7:0] cnt;
      logic ap_valid;
      logic ap_write;
      logic [4:0] ap_addr;
      logic [12:0] addr_reg;
      logic [7:0] wdata_reg;
      logic [7:0] rdata;
      logic refused;
      logic prog_done;
      logic toggle_seen;
      logic [12:0] last_addr;
      logic [7:0] last_data;
      logic page_open;
      logic [6:0] page_base;
      logic [6:0] page_cnt;
      logic [15:0] win_cnt;
      logic [7:0] d_s1;
      logic [7:0] d_s2;
      logic [12:0] a_out;
      logic [7:0] d_out;
      logic d_oe;
      logic cs_n;
      logic oe_n;
      logic we_n;
   } pewc_state_s_t;
endpackage

// >>> pewc_top.sv
// host-side controller for a byte-wide parallel EEPROM with async strobes
// software drives it over AHB-Lite; the EEPROM pins are driven directly,
// the data pins as in / out / enable, the inputs synchronised by two flops
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`include "pewc_defines.svh"
module pewc_top
   import pewc_pkg::*;
#(
   parameter int BLW_CYC = `PEWC_BLW_CYC,
   parameter int STROBE_CYC = `PEWC_STROBE_CYC,
   parameter int ACCESS_CYC = `PEWC_ACCESS_CYC
)
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // ahb-lite slave
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   output logic [31:0] HRDATA_OUT,
   // eeprom pins
   output logic [12:0] ADDRESS_OUT,
   input wire logic [7:0] DATA_PINS_IN,
   output logic [7:0] DATA_PINS_OUT,
   output logic DATA_PINS_OE_OUT,
   output logic CHIP_SELECT_N_OUT,
   output logic OUTPUT_DRIVE_N_OUT,
   output logic WRITE_STROBE_N_OUT
);
   // counters are 16 and 8 bits wide; refuse counts they cannot hold
   if (BLW_CYC < 1 || BLW_CYC > 65535)
      $error("BLW_CYC out of range");
   if (STROBE_CYC < 1 || STROBE_CYC > 250 || ACCESS_CYC < 1 || ACCESS_CYC > 250)
      $error("strobe or access count out of range");

   localparam logic [7:0] STROBE_C = 8'(STROBE_CYC);
   localparam logic [7:0] READ_WAIT_C = 8'(ACCESS_CYC + `PEWC_SYNC_CYC);
   localparam logic [15:0] BLW_C = 16'(BLW_CYC);
   localparam logic [6:0] PAGE_MAX_C = 7'(`PEWC_PAGE_BYTES);

   pewc_state_s_t s;
   pewc_state_s_t n;

   function automatic logic [2:0] seq_len(input pewc_cmd_t k);
      case (k)
         PEWC_CMD_UNLOCK: seq_len = 3'h3;
         PEWC_CMD_UNPROT: seq_len = 3'h6;
         default: seq_len = 3'h1;
      endcase
   endfunction

   // steps 0,1 (and 3,4 of the six-write clear) are the common AA/55 pair
   function automatic logic [20:0] seq_step(input pewc_cmd_t k, input logic [2:0] i,
                                           input logic [12:0] a, input logic [7:0] d);
      if (k == PEWC_CMD_LOAD)
         seq_step = {a, d};
      else if (i == 3'h0 || i == 3'h3)
         seq_step = {`PEWC_SEQ_A1, `PEWC_SEQ_D1};
      else if (i == 3'h1 || i == 3'h4)
         seq_step = {`PEWC_SEQ_A2, `PEWC_SEQ_D2};
      else if (k == PEWC_CMD_UNLOCK)
         seq_step = {`PEWC_SEQ_A1, `PEWC_SEQ_D3_UNLOCK};
      else if (i == 3'h2)
         seq_step = {`PEWC_SEQ_A1, `PEWC_SEQ_D3_UNPROT};
      else
         seq_step = {`PEWC_SEQ_A1, `PEWC_SEQ_D6_UNPROT};
   endfunction

   logic busy;
   logic [31:0] status_word;
   assign busy = (s.st != PEWC_IDLE);
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[`PEWC_ST_BUSY] = busy;
      status_word[`PEWC_ST_PAGE_OPEN] = s.page_open;
      status_word[`PEWC_ST_REFUSED] = s.refused;
      status_word[`PEWC_ST_PROG_DONE] = s.prog_done;
      status_word[`PEWC_ST_TOGGLE] = s.toggle_seen;
   end

   always_comb
   begin
      logic wr_cmd;
      logic [20:0] step;
      pewc_cmd_t req;
      wr_cmd = 1'b0;
      step = 21'h0;
      req = PEWC_CMD_NONE;
      n = s;
      n.d_s1 = DATA_PINS_IN;
      n.d_s2 = s.d_s1;
      // ahb address phase taken on hready; write data follows a cycle later
      n.ap_valid = HSEL_IN && HREADY_IN && HTRANS_IN[1];
      n.ap_write = HWRITE_IN;
      n.ap_addr = HADDR_IN[4:0];
      if (s.ap_valid && s.ap_write)
      begin
         case (s.ap_addr)
            `PEWC_REG_CMD:
            begin
               wr_cmd = 1'b1;
               req = pewc_cmd_t'(HWDATA_IN[2:0]);
            end
            `PEWC_REG_ADDR: n.addr_reg = HWDATA_IN[12:0];
            `PEWC_REG_WDATA: n.wdata_reg = HWDATA_IN[7:0];
            `PEWC_REG_STATUS:
               if (HWDATA_IN[`PEWC_ST_REFUSED])
                  n.refused = 1'b0;
            default: ;
         endcase
      end
      // page window: no falling load strobe within the window closes the page
      if (s.page_open)
      begin
         if (s.win_cnt == 16'h0000)
            n.page_open = 1'b0;
         else
            n.win_cnt = s.win_cnt - 16'h0001;
      end
      case (s.st)
         PEWC_IDLE:
         begin
            n.cs_n = 1'b1;
            n.oe_n = 1'b1;
            n.we_n = 1'b1;
            n.d_oe = 1'b0;
            n.idx = 3'h0;
            if (wr_cmd && (req == PEWC_CMD_READ || req == PEWC_CMD_POLL))
            begin
               n.kind = req;
               n.a_out = (req == PEWC_CMD_POLL) ? s.last_addr : s.addr_reg;
               n.cnt = READ_WAIT_C;
               n.st = PEWC_R_ACC;
            end
            else if (wr_cmd && (req == PEWC_CMD_UNLOCK || req == PEWC_CMD_UNPROT))
            begin
               n.kind = req;
               n.st = PEWC_W_SEL;
            end
            else if (wr_cmd && req == PEWC_CMD_LOAD)
            begin
               // page loads stay inside one page and within its size
               if (s.page_open && (s.addr_reg[12:6] != s.page_base ||
                                    s.page_cnt == PAGE_MAX_C))
                  n.refused = 1'b1;
               else
               begin
                  n.kind = req;
                  n.st = PEWC_W_SEL;
               end
            end
         end
         PEWC_W_SEL:
         begin
            // address, data and select all change at the same edge, output drive held high
            step = seq_step(s.kind, s.idx, s.addr_reg, s.wdata_reg);
            n.a_out = step[20:8];
            n.d_out = step[7:0];
            n.d_oe = 1'b1;
            n.oe_n = 1'b1;
            n.cs_n = 1'b0;
            n.cnt = STROBE_C;
            n.st = PEWC_W_LOW;
         end
         PEWC_W_LOW:
         begin
            // strobe falls after select, so the address is latched here
            n.we_n = 1'b0;
            if (s.we_n && s.kind == PEWC_CMD_LOAD)
            begin
               n.win_cnt = BLW_C;
               n.prog_done = 1'b0;
               n.last_addr = s.a_out;
               n.last_data = s.d_out;
               if (!s.page_open)
               begin
                  n.page_open = 1'b1;
                  n.page_base = s.a_out[12:6];
                  n.page_cnt = 7'h01;
               end
               else
                  n.page_cnt = s.page_cnt + 7'h01;
            end
            if (s.cnt == 8'h00)
            begin
               // strobe rises first, data still driven: data latched here
               n.we_n = 1'b1;
               n.st = PEWC_W_REL;
            end
            else
               n.cnt = s.cnt - 8'h01;
         end
         PEWC_W_REL:
         begin
            n.cs_n = 1'b1;
            if (s.idx + 3'h1 == seq_len(s.kind))
            begin
               n.idx = 3'h0;
               n.st = PEWC_IDLE;
            end
            else
            begin
               // command steps follow back to back, nothing in between
               n.idx = s.idx + 3'h1;
               n.st = PEWC_W_SEL;
            end
         end
         PEWC_R_ACC:
         begin
            n.d_oe = 1'b0;
            n.we_n = 1'b1;
            n.cs_n = 1'b0;
            n.oe_n = 1'b0;
            if (s.cnt == 8'h00)
            begin
               n.rdata = s.d_s2;
               if (s.kind == PEWC_CMD_POLL)
               begin
                  // bit 7 equal to bit 7 of the last loaded byte means programming ended; bit 6 kept for toggle checks
                  n.prog_done = (s.d_s2[7] == s.last_data[7]);
                  n.toggle_seen = s.d_s2[6];
               end
               n.st = PEWC_R_END;
            end
            else
               n.cnt = s.cnt - 8'h01;
         end
         PEWC_R_END:
         begin
            n.cs_n = 1'b1;
            n.oe_n = 1'b1;
            n.st = PEWC_IDLE;
         end
         default: n.st = PEWC_IDLE;
      endcase
   end

   always_ff @(posedge CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         s <= '0;
         s.st <= PEWC_IDLE;
         s.kind <= PEWC_CMD_NONE;
         s.prog_done <= 1'b1;
         s.cs_n <= 1'b1;
         s.oe_n <= 1'b1;
         s.we_n <= 1'b1;
      end
      else
         s <= n;
   end

   // register reads answer in the data phase with zero wait states
   always_comb
   begin
      case (s.ap_addr)
         `PEWC_REG_ADDR: HRDATA_OUT = {19'h0, s.addr_reg};
         `PEWC_REG_WDATA: HRDATA_OUT = {24'h0, s.wdata_reg};
         `PEWC_REG_STATUS: HRDATA_OUT = status_word;
         `PEWC_REG_RDATA: HRDATA_OUT = {24'h0, s.rdata};
         default: HRDATA_OUT = 32'h0000_0000;
      endcase
   end

   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT = 1'b0;
   assign ADDRESS_OUT = s.a_out;
   assign DATA_PINS_OUT = s.d_out;
   assign DATA_PINS_OE_OUT = s.d_oe;
   assign CHIP_SELECT_N_OUT = s.cs_n;
   assign OUTPUT_DRIVE_N_OUT = s.oe_n;
   assign WRITE_STROBE_N_OUT = s.we_n;
endmodule

// >>> pewc_top_chk.sv
// assertion checker on the EEPROM pins of pewc_top
// assumes the bind at the foot; sees the top module's ports only
module pewc_chk
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // eeprom pins
   input wire logic [12:0] ADDRESS_OUT,
   input wire logic [7:0] DATA_PINS_OUT,
   input wire logic DATA_PINS_OE_OUT,
   input wire logic CHIP_SELECT_N_OUT,
   input wire logic OUTPUT_DRIVE_N_OUT,
   input wire logic WRITE_STROBE_N_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge CLK_IN);
   endclocking
   default disable iff (!NRST_IN);
   property p_wr_lvl;
      !WRITE_STROBE_N_OUT |-> OUTPUT_DRIVE_N_OUT && !CHIP_SELECT_N_OUT;
   endproperty
   a_wr_lvl: assert property (p_wr_lvl) else $error("strobe low out of write");
   property p_rd_lvl;
      !OUTPUT_DRIVE_N_OUT |-> !CHIP_SELECT_N_OUT && WRITE_STROBE_N_OUT && !DATA_PINS_OE_OUT;
   endproperty
   a_rd_lvl: assert property (p_rd_lvl) else $error("bad read levels");
   property p_idle;
      CHIP_SELECT_N_OUT |-> WRITE_STROBE_N_OUT && OUTPUT_DRIVE_N_OUT;
   endproperty
   a_idle: assert property (p_idle) else $error("strobe without select");
   property p_addr_hold;
      !WRITE_STROBE_N_OUT |-> $stable(ADDRESS_OUT);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   property p_data_hold;
      !WRITE_STROBE_N_OUT |-> DATA_PINS_OE_OUT && $stable(DATA_PINS_OUT);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("write data moved");
   property p_strobe_len;
      $fell(WRITE_STROBE_N_OUT) |-> !WRITE_STROBE_N_OUT [*8] ##[1:6] WRITE_STROBE_N_OUT;
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("strobe width");
   property p_sel_after;
      $rose(WRITE_STROBE_N_OUT) |-> !CHIP_SELECT_N_OUT && DATA_PINS_OE_OUT ##1 CHIP_SELECT_N_OUT;
   endproperty
   a_sel_after: assert property (p_sel_after) else $error("select released early");
   property p_rd_len;
      $fell(OUTPUT_DRIVE_N_OUT) |-> !DATA_PINS_OE_OUT throughout !OUTPUT_DRIVE_N_OUT [*8];
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("read too short");
   c_write: cover property ($fell(WRITE_STROBE_N_OUT));
   c_read: cover property ($fell(OUTPUT_DRIVE_N_OUT));
   c_pair: cover property ($rose(CHIP_SELECT_N_OUT) ##[1:4] $fell(CHIP_SELECT_N_OUT));
endmodule

bind pewc_top pewc_chk i_chk
(
   .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .ADDRESS_OUT(ADDRESS_OUT),
   .DATA_PINS_OUT(DATA_PINS_OUT), .DATA_PINS_OE_OUT(DATA_PINS_OE_OUT),
   .CHIP_SELECT_N_OUT(CHIP_SELECT_N_OUT), .OUTPUT_DRIVE_N_OUT(OUTPUT_DRIVE_N_OUT),
   .WRITE_STROBE_N_OUT(WRITE_STROBE_N_OUT)
);

// >>> pewc_mem_model.sv
// behavioural byte-wide EEPROM: page load, status bits, software protection
// assumes host pins from pewc_top; it also resolves the shared data wire
module pewc_mem_model
#(
   parameter int BLW_NS = 2000,
   parameter int WC_NS = 20000
)
(
   // host pins
   input wire logic [12:0] addr_in,
   input wire logic [7:0] host_d_in,
   input wire logic host_oe_in,
   input wire logic cs_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   // supply sense, high while the supply is too low to write
   input wire logic vcc_low_in,
   // data wire level
   output logic [7:0] wire_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [8192];
   logic [12:0] pa [64];
   logic [7:0] pd [64];
   logic [12:0] sa [6] = '{13'h1555, 13'h0AAA, 13'h1555, 13'h1555, 13'h0AAA, 13'h1555};
   logic [7:0] sd [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h20};
   logic [12:0] a_lat;
   logic [7:0] rd = 8'hFF, last_d;
   logic [6:0] base;
   logic busy = 1'h0, tog = 1'h0, unl = 1'h0, clr = 1'h0, armed = 1'h0;
   logic prot = 1'h0;
   int cnt = 0, seq = 0;
   time t0;
   // a released wire shows the inverse of the last read, never a stale copy
   assign wire_out = (!cs_n_in && !oe_n_in) ? rd : host_oe_in ? host_d_in : ~rd;
   initial foreach (mem[i]) mem[i] = 8'hFF;
   always @(negedge cs_n_in or negedge we_n_in)
      if (!cs_n_in && !we_n_in && oe_n_in)
      begin
         a_lat = addr_in;
         armed = 1'h1;
      end
   always @(posedge cs_n_in or posedge we_n_in)
      if (armed)
      begin
         armed = 1'h0;
         take(a_lat, wire_out);
      end
   always @(negedge we_n_in)
   begin
      t0 = $time;
      fork
         #(BLW_NS) if ($time - t0 >= BLW_NS) program_page();
      join_none
   end
   always @(negedge oe_n_in or negedge cs_n_in)
      if (!oe_n_in && !cs_n_in)
      begin
         #1;
         tog = tog ^ busy;
         rd = busy ? {~last_d[7], tog, last_d[5:0]} : mem[addr_in];
      end
   task automatic take(input logic [12:0] a, input logic [7:0] d);
      if (busy || vcc_low_in)
         return;
      if (seq == 2 && a == sa[2] && d == 8'hA0)
      begin
         prot = 1'h1;
         unl = 1'h1;
         seq = 0;
      end
      else if (a == sa[seq] && d == sd[seq])
      begin
         seq = (seq == 5) ? 0 : seq + 1;
         clr = clr | (seq == 0);
      end
      else
      begin
         seq = 0;
         if (cnt == 0)
            base = a[12:6];
         if ((!prot || unl) && a[12:6] == base && cnt < 64)
         begin
            pa[cnt] = a;
            pd[cnt] = d;
            last_d = d;
            cnt++;
         end
      end
   endtask
   task automatic program_page();
      if (busy || (cnt == 0 && !clr))
         return;
      busy = 1'h1;
      #(WC_NS);
      for (int i = 0; i < cnt; i++)
         mem[pa[i]] = pd[i];
      prot = prot && !clr;
      cnt = 0;
      unl = 1'h0;
      clr = 1'h0;
      busy = 1'h0;
   endtask
endmodule

// >>> tb_parallel_eeprom_write_control.sv
// bench for pewc_top: AHB-Lite master, random page loads, protection flow
// assumes pewc_top, pewc_mem_model and the bound checker are compiled
`include "pewc_defines.svh"
module tb_parallel_eeprom_write_control import pewc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BLW = 200;
   localparam int WC = 2100;
   logic clk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0, b4;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv;
   logic [6:0] pg;
   logic [12:0] a;
   logic [7:0] d;
   logic [7:0] exp_mem [logic [12:0]];
   wire logic hready, hresp, d_oe, cs_n, od_n, we_n;
   wire logic [31:0] hrdata;
   wire logic [12:0] addr;
   wire logic [7:0] d_out, d_in;
   int seed = 32'hFC9655A3;
   int errors = 0;
   int total_checks = 0;
   logic vcc_low = 1'h0;
   always #5 clk = ~clk;
   pewc_top #(.BLW_CYC(BLW)) i_dut
   (
      .CLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .HRDATA_OUT(hrdata), .ADDRESS_OUT(addr),
      .DATA_PINS_IN(d_in), .DATA_PINS_OUT(d_out), .DATA_PINS_OE_OUT(d_oe),
      .CHIP_SELECT_N_OUT(cs_n), .OUTPUT_DRIVE_N_OUT(od_n), .WRITE_STROBE_N_OUT(we_n)
   );
   pewc_mem_model #(.BLW_NS(BLW * 10), .WC_NS(20000)) i_mem
   (
      .addr_in(addr), .host_d_in(d_out), .host_oe_in(d_oe), .cs_n_in(cs_n),
      .oe_n_in(od_n), .we_n_in(we_n), .vcc_low_in(vcc_low), .wire_out(d_in)
   );
   task automatic conclude();
      if (errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want)
      begin
         errors++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] ra, input logic [31:0] wd);
      logic rdy;
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {27'h0, ra};
      hwrite <= w;
      // slave seen mid-cycle, as it stands at the next edge, never racing it
      do
      begin
         @(negedge clk);
         rdy = hready;
         @(posedge clk);
      end
      while (rdy !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      do
      begin
         @(negedge clk);
         rdy = hready;
         rdv = hrdata;
         @(posedge clk);
      end
      while (rdy !== 1'h1);
   endtask
   task automatic cmd(input pewc_cmd_t c);
      bus(1'h1, `PEWC_REG_CMD, {29'h0, c});
      do bus(1'h0, `PEWC_REG_STATUS, 32'h0); while (rdv[0] !== 1'h0);
   endtask
   task automatic load(input logic [12:0] la, input logic [7:0] ld, input logic keep);
      bus(1'h1, `PEWC_REG_ADDR, {19'h0, la});
      bus(1'h1, `PEWC_REG_WDATA, {24'h0, ld});
      cmd(PEWC_CMD_LOAD);
      if (keep)
         exp_mem[la] = ld;
   endtask
   // a load the controller must turn away, then the sticky flag cleared
   task automatic refuse(input logic [12:0] la);
      load(la, 8'h5A, 1'h0);
      bus(1'h0, `PEWC_REG_STATUS, 32'h0);
      check(rdv[2:1], 2'h3);
      bus(1'h1, `PEWC_REG_STATUS, 32'h4);
      bus(1'h0, `PEWC_REG_STATUS, 32'h0);
      check(rdv[2], 0);
   endtask
   function automatic logic [31:0] want_rd(input logic [12:0] wa);
      return {24'h0, exp_mem.exists(wa) ? exp_mem[wa] : 8'hFF};
   endfunction
   task automatic readback(input logic [12:0] ra);
      bus(1'h1, `PEWC_REG_ADDR, {19'h0, ra});
      cmd(PEWC_CMD_READ);
      bus(1'h0, `PEWC_REG_RDATA, 32'h0);
      check(rdv, want_rd(ra));
      check({31'h0, hresp}, 32'h0);
   endtask
   // the window must lapse first, or an old cell can fake a finished poll
   task automatic prog_wait();
      int n;
      n = 0;
      repeat (BLW + 10) @(posedge clk);
      do
      begin
         cmd(PEWC_CMD_POLL);
         if (n == 0) check(rdv[3], 0);
         if (n > 0 && rdv[3] === 1'h0) check(rdv[4] ^ b4, 1);
         b4 = rdv[4];
         n++;
      end
      while (rdv[3] !== 1'h1);
      cmd(PEWC_CMD_POLL);
      check(rdv[4:3], {b4, 1'h1});
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      errors++;
      conclude();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      bus(1'h1, 5'h14, 32'($random(seed)));
      bus(1'h0, `PEWC_REG_STATUS, 32'h0);
      check(rdv, 32'h8);
      pg = 7'($random(seed)) & 7'h1F;
      // a full page, a stray page early on, then a 65th load into the page
      for (int i = 0; i < 64; i++)
      begin
         load({pg, 6'(i)}, 8'($random(seed)), 1'h1);
         if (i == 3)
            refuse({pg + 7'h1, 6'h0});
      end
      refuse({pg, 6'h3F});
      prog_wait();
      for (int i = 0; i < 64; i++)
         readback({pg, 6'(i)});
      readback({pg + 7'h1, 6'h0});
      a = {pg, 6'h11};
      d = 8'($random(seed));
      cmd(PEWC_CMD_UNLOCK);
      load(a, d, 1'h1);
      prog_wait();
      readback(a);
      load(a, ~d, 1'h0);
      repeat (BLW + WC) @(posedge clk);
      readback(a);
      cmd(PEWC_CMD_UNPROT);
      repeat (BLW + WC) @(posedge clk);
      load(a, ~d, 1'h1);
      prog_wait();
      readback(a);
      // low supply: the load reaches the pins but must not program
      vcc_low <= 1'h1;
      load(a, d, 1'h0);
      repeat (BLW + WC) @(posedge clk);
      readback(a);
      vcc_low <= 1'h0;
      conclude();
   end
endmodule
